//--- inc/tcprc_pkg.sv
// tcprc_pkg: register indices, role codes, commands, timing counts
// shared by the port controller end and the manager end.
package tcprc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register indices on the link
    localparam logic [7:0] REG_ALERT = 8'h10;
    localparam logic [7:0] REG_PWR_STATUS = 8'h1E;
    localparam logic [7:0] REG_ROLE = 8'h1A;
    localparam logic [7:0] REG_PWR_CTRL = 8'h1C;
    localparam logic [7:0] REG_DRAIN_CTRL = 8'h1D;
    localparam logic [7:0] REG_CC_GEN = 8'h1F;
    localparam logic [7:0] REG_CMD = 8'h23;
    localparam logic [7:0] REG_VBUS_VOLT = 8'h70;
    localparam logic [7:0] REG_SNK_THR = 8'h72;
    localparam logic [7:0] REG_CC_STATUS = 8'h1B;
    // field positions
    localparam int ALERT_CC_BIT = 0;
    localparam int ALERT_PWR_BIT = 1;
    localparam int INIT_PEND_BIT = 6;
    localparam int PWRC_FORCE_BIT = 2;
    localparam int PWRC_AUTO_BIT = 4;
    localparam int PWRC_MEAS_BIT = 6;
    localparam int DRAIN_OFF_BIT = 0;
    // role codes
    localparam logic [7:0] ROLE_SRC = 8'h05;
    localparam logic [7:0] ROLE_SRC_1A5 = 8'h15;
    localparam logic [7:0] ROLE_SRC_3A = 8'h25;
    localparam logic [7:0] ROLE_SNK = 8'h0A;
    localparam logic [7:0] ROLE_DRP = 8'h4A;
    // commands
    localparam logic [7:0] CMD_SEARCH = 8'h99;
    localparam logic [7:0] CMD_SRC_DEF = 8'h77;
    localparam logic [7:0] CMD_SRC_HI = 8'h88;
    localparam logic [7:0] CMD_SRC_OFF = 8'h66;
    localparam logic [7:0] CMD_SINK = 8'h55;
    // termination encodings
    typedef enum logic [2:0] {
        TERM_OPEN = 3'b000,
        TERM_PD = 3'b001,
        TERM_PU_DEF = 3'b010,
        TERM_PU_1A5 = 3'b011,
        TERM_PU_3A = 3'b100
    } tcprc_term_t;
    // timing: toggle period 50..100 ms, source share 30..70 %
    localparam int DRP_PERIOD_MS = 75;
    localparam int DRP_SRC_PCT = 50;
    localparam int INIT_US = 1000;
    localparam int MEAS_US = 2000;
    localparam int DRP_PERIOD_CYC = CLK_HZ / 1000 * DRP_PERIOD_MS;
    localparam int INIT_CYC = CLK_HZ / 1_000_000 * INIT_US;
    localparam int MEAS_CYC = CLK_HZ / 1_000_000 * MEAS_US;
    localparam int CNT_W = 24;
    localparam logic [7:0] VSAFE0_CODE = 8'h08;
endpackage : tcprc_pkg

//--- inc/tcprc_if.sv
// tcprc_if: register link between port controller and manager,
// plus the alert line. assumes both ends on sys_clk.
`timescale 1ns/1ps
interface tcprc_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic alert_n;
    modport dev (input addr, input wdata, input wr, input rd, output rdata, output alert_n);
    modport mgr (output addr, output wdata, output wr, output rd, input rdata, input alert_n);
endinterface : tcprc_if

//--- src/tcprc_dev.sv
// tcprc_dev: port controller end; terminations, alert, supply control.
// assumes manager on same clock; analog inputs already synchronised
// by the pin pads' two-stage capture inside this module.
`timescale 1ns/1ps
// How it works
// - source code applies pull-ups on both lines
// - 0x15 and 0x25 raise advertised current
// - sink code applies pull-downs on both lines
// - dual-role code plus search toggles terminations
// - source keeps watching both lines until attach
// - attach drives active-low alert line
// - power-up sets alert bit 1, alert low
// - init pending flag clears when ready
// - write one clears alert bit
// - manager clears alert, writes role, searches
// - toggle period between 50 and 100 ms
// - source share between 30 and 70 percent
// - manual dual-role alternates sink/source writes; a role write takes effect only at the next search command
// - toggle setup before search command
// - source supply commands accepted, no action
// - sink supply command ignored
// - measure enable stores supply reading
// - force bit starts discharge
// - automatic discharge on attach/detach conditions
// - drain-off bit blocks internal discharge
// - manager opens supply switch around discharge; tcprc_mgr has no switch control, it is left to user logic
// - source detach discharges to safe zero
// - sink threshold crossing discharges rail
module tcprc_dev (
    input wire logic sys_clk,
    input wire logic rst,
    tcprc_if.dev bus,
    input wire logic cc1_partner,
    input wire logic cc2_partner,
    input wire logic [7:0] vbus_level,
    output tcprc_pkg::tcprc_term_t cc1_term,
    output tcprc_pkg::tcprc_term_t cc2_term,
    output logic drain_on,
    output logic attached
);
    import tcprc_pkg::*;
    logic [1:0] cc1_s, cc2_s;
    logic [7:0] vb_s1, vb_s2;
    logic [7:0] alert, role, role_live, pwr_ctrl, drain_ctrl, cc_gen, vbus_volt, snk_thr;
    logic init_pend, searching, drp_src, src_live;
    logic [CNT_W-1:0] init_cnt, drp_cnt, meas_cnt;
    logic partner_seen, was_attached, above_thr;
    tcprc_term_t next_term;

    // two-stage capture of pad inputs
    always_ff @(posedge sys_clk) begin
        cc1_s <= {cc1_s[0], cc1_partner};
        cc2_s <= {cc2_s[0], cc2_partner};
        vb_s1 <= vbus_level;
        vb_s2 <= vb_s1;
    end
    assign partner_seen = cc1_s[1] | cc2_s[1];

    function automatic tcprc_term_t pu_of(input logic [7:0] r);
        if (r == ROLE_SRC_3A) pu_of = TERM_PU_3A;
        else if (r == ROLE_SRC_1A5) pu_of = TERM_PU_1A5;
        else pu_of = TERM_PU_DEF;
    endfunction : pu_of

    // power-up readiness
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            init_cnt <= '0;
            init_pend <= 1'b1;
        end else if (init_pend) begin
            if (init_cnt == CNT_W'(INIT_CYC - 1)) init_pend <= 1'b0;
            else init_cnt <= init_cnt + 1'b1;
        end
    end

    // alert flags, set wins over write-one clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alert <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (bus.wr && bus.addr == REG_ALERT && bus.wdata[i]) alert[i] <= 1'b0;
            end
            if (init_pend && init_cnt == CNT_W'(INIT_CYC - 1)) alert[ALERT_PWR_BIT] <= 1'b1;
            if (searching && partner_seen && !was_attached) alert[ALERT_CC_BIT] <= 1'b1;
        end
    end

    // control registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            role <= ROLE_SNK;
            pwr_ctrl <= 8'h00;
            drain_ctrl <= 8'h00;
            cc_gen <= 8'h00;
            snk_thr <= 8'h00;
        end else if (bus.wr) begin
            if (bus.addr == REG_ROLE) role <= bus.wdata;
            else if (bus.addr == REG_PWR_CTRL) pwr_ctrl <= bus.wdata;
            else if (bus.addr == REG_DRAIN_CTRL) drain_ctrl <= bus.wdata;
            else if (bus.addr == REG_CC_GEN) cc_gen <= bus.wdata;
            else if (bus.addr == REG_SNK_THR) snk_thr <= bus.wdata;
        end
    end

    // commands: only search acts; supply notices have no effect
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            searching <= 1'b0;
            role_live <= 8'h00;
        end else if (bus.wr && bus.addr == REG_CMD) begin
            if (bus.wdata == CMD_SEARCH) begin
                searching <= 1'b1;
                role_live <= role;
            end
            // other command codes fall through untouched
        end else if (bus.wr && bus.addr == REG_ROLE && !searching) begin
            role_live <= role_live;
        end
    end

    // autonomous toggle timer
    always_ff @(posedge sys_clk) begin
        if (rst || !searching || role_live != ROLE_DRP || was_attached) begin
            drp_cnt <= '0;
            drp_src <= 1'b0;
        end else begin
            if (drp_cnt == CNT_W'(DRP_PERIOD_CYC - 1)) drp_cnt <= '0;
            else drp_cnt <= drp_cnt + 1'b1;
            // sink half first, source half closes the period
            drp_src <= drp_cnt >= CNT_W'(DRP_PERIOD_CYC / 100 * (100 - DRP_SRC_PCT));
        end
    end

    always_comb begin
        next_term = TERM_OPEN;
        if (role_live == ROLE_DRP) next_term = drp_src ? TERM_PU_DEF : TERM_PD;
        else if (role_live == ROLE_SNK) next_term = TERM_PD;
        else if (role_live[3:0] == ROLE_SRC[3:0]) next_term = pu_of(role_live);
    end
    assign src_live = (cc1_term == TERM_PU_DEF) || (cc1_term == TERM_PU_1A5)
        || (cc1_term == TERM_PU_3A);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cc1_term <= TERM_OPEN;
            cc2_term <= TERM_OPEN;
        end else if (searching && !was_attached) begin
            cc1_term <= next_term;
            cc2_term <= next_term;
        end
    end

    // attach watch; keeps monitoring both lines while unattached
    always_ff @(posedge sys_clk) begin
        if (rst || !searching) begin
            was_attached <= 1'b0;
        end else begin
            was_attached <= partner_seen;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) attached <= 1'b0;
        else attached <= was_attached;
    end

    // supply measurement
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meas_cnt <= '0;
            vbus_volt <= 8'h00;
        end else if (pwr_ctrl[PWRC_MEAS_BIT]) begin
            if (meas_cnt == CNT_W'(MEAS_CYC - 1)) begin
                meas_cnt <= '0;
                vbus_volt <= vb_s2;
            end else meas_cnt <= meas_cnt + 1'b1;
        end
    end
    assign above_thr = vb_s2 > snk_thr;

    // discharge control
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drain_on <= 1'b0;
        end else if (drain_ctrl[DRAIN_OFF_BIT]) begin
            drain_on <= 1'b0;
        end else if (pwr_ctrl[PWRC_FORCE_BIT]) begin
            drain_on <= 1'b1;
        end else if (pwr_ctrl[PWRC_AUTO_BIT] && src_live && was_attached && !partner_seen) begin
            drain_on <= 1'b1;
        end else if (pwr_ctrl[PWRC_AUTO_BIT] && cc1_term == TERM_PD && snk_thr != 8'h00
                && !above_thr && was_attached) begin
            drain_on <= 1'b1;
        end else if (vb_s2 <= VSAFE0_CODE) begin
            drain_on <= 1'b0;
        end
    end

    // alert line and read port
    always_ff @(posedge sys_clk) begin
        if (rst) bus.alert_n <= 1'b1;
        else bus.alert_n <= ~|alert;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) bus.rdata <= 8'h00;
        else if (bus.rd) begin
            if (bus.addr == REG_ALERT) bus.rdata <= alert;
            else if (bus.addr == REG_PWR_STATUS) bus.rdata <= 8'(init_pend) << INIT_PEND_BIT;
            else if (bus.addr == REG_ROLE) bus.rdata <= role;
            else if (bus.addr == REG_PWR_CTRL) bus.rdata <= pwr_ctrl;
            else if (bus.addr == REG_DRAIN_CTRL) bus.rdata <= drain_ctrl;
            else if (bus.addr == REG_CC_GEN) bus.rdata <= cc_gen;
            else if (bus.addr == REG_VBUS_VOLT) bus.rdata <= vbus_volt;
            else if (bus.addr == REG_SNK_THR) bus.rdata <= snk_thr;
            else if (bus.addr == REG_CC_STATUS) bus.rdata <= {7'h00, was_attached};
            else bus.rdata <= 8'h00;
        end
    end
endmodule : tcprc_dev

//--- src/tcprc_mgr.sv
// tcprc_mgr: manager end; brings the controller up and sets its role.
// assumes controller on the same clock; user side is a plain port.
`timescale 1ns/1ps
module tcprc_mgr (
    input wire logic sys_clk,
    input wire logic rst,
    tcprc_if.mgr bus,
    input wire logic start,
    input wire logic [7:0] role_sel,
    output logic ready,
    output logic alert_seen
);
    import tcprc_pkg::*;
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_RD_ALERT = 3'b001,
        M_RD_STAT = 3'b010,
        M_CHECK = 3'b011,
        M_CLEAR = 3'b100,
        M_ROLE = 3'b101,
        M_SEARCH = 3'b110,
        M_DONE = 3'b111
    } tcprc_mstate_t;
    tcprc_mstate_t state;
    logic [1:0] alert_s;
    logic [7:0] role_hold;

    always_ff @(posedge sys_clk) alert_s <= {alert_s[0], bus.alert_n};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= M_IDLE;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.addr <= 8'h00;
            bus.wdata <= 8'h00;
            ready <= 1'b0;
            alert_seen <= 1'b0;
            role_hold <= ROLE_SNK;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            alert_seen <= !alert_s[1];
            case (state)
                M_IDLE: begin
                    if (start) role_hold <= role_sel;
                    if (!alert_s[1]) begin
                        bus.rd <= 1'b1;
                        bus.addr <= REG_ALERT;
                        state <= M_RD_ALERT;
                    end
                end
                M_RD_ALERT: begin
                    bus.rd <= 1'b1;
                    bus.addr <= REG_PWR_STATUS;
                    state <= M_RD_STAT;
                end
                M_RD_STAT: state <= M_CHECK;
                M_CHECK: begin
                    if (bus.rdata[INIT_PEND_BIT]) state <= M_IDLE;
                    else state <= M_CLEAR;
                end
                M_CLEAR: begin
                    bus.wr <= 1'b1;
                    bus.addr <= REG_ALERT;
                    bus.wdata <= 8'h01 << ALERT_PWR_BIT;
                    state <= M_ROLE;
                end
                M_ROLE: begin
                    bus.wr <= 1'b1;
                    bus.addr <= REG_ROLE;
                    bus.wdata <= role_hold;
                    state <= M_SEARCH;
                end
                M_SEARCH: begin
                    bus.wr <= 1'b1;
                    bus.addr <= REG_CMD;
                    bus.wdata <= CMD_SEARCH;
                    ready <= 1'b1;
                    state <= M_DONE;
                end
                M_DONE: begin
                    // supply switch lives in user logic
                    if (!alert_s[1]) begin
                        bus.wr <= 1'b1;
                        bus.addr <= REG_ALERT;
                        bus.wdata <= 8'hFF;
                    end
                end
                default: state <= M_IDLE;
            endcase
        end
    end
endmodule : tcprc_mgr

//--- dv/tcprc_properties.sv
// tcprc_properties: link checks between manager end and controller end.
// assumes one clock and a synchronous active-high reset; sits beside the link.
`timescale 1ns/1ps
module tcprc_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic alert_n
);
    import tcprc_pkg::*;
    logic [CNT_W-1:0] up_cyc;
    logic seen_low;
    logic clr_seen;
    logic role_seen;
    // cycles since reset release, saturating past the init span
    always_ff @(posedge sys_clk) begin
        if (rst) up_cyc <= '0;
        else if (up_cyc < CNT_W'(INIT_CYC + 8)) up_cyc <= up_cyc + 1'b1;
    end
    // bring-up progress as seen on the link
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seen_low <= 1'b0;
            clr_seen <= 1'b0;
            role_seen <= 1'b0;
        end else begin
            if (!alert_n) seen_low <= 1'b1;
            if (wr && addr == REG_ALERT && wdata[ALERT_PWR_BIT]) clr_seen <= 1'b1;
            if (wr && addr == REG_ROLE) role_seen <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_one_strobe: assert property (!(wr && rd))
        else $error("read and write strobes high together");
    a_alert_early: assert property (!alert_n |-> up_cyc >= CNT_W'(INIT_CYC - 2))
        else $error("alert low before init span ended");
    a_alert_late: assert property (up_cyc == CNT_W'(INIT_CYC + 4) |-> seen_low || !alert_n)
        else $error("alert not raised after init span");
    a_clear_raises: assert property (
        wr && addr == REG_ALERT && wdata[ALERT_PWR_BIT] && !role_seen |-> ##[1:3] alert_n)
        else $error("alert line stayed low after clear");
    a_alert_bit: assert property (
        rd && addr == REG_ALERT && !alert_n && !role_seen |=> rdata[ALERT_PWR_BIT])
        else $error("power alert bit not read back");
    a_ready_flag: assert property (
        rd && addr == REG_PWR_STATUS && up_cyc > CNT_W'(INIT_CYC + 2) |=> !rdata[INIT_PEND_BIT])
        else $error("init pending flag still set");
    a_rdata_holds: assert property (!$past(rd) |-> $stable(rdata))
        else $error("read data changed without a read");
    a_role_order: assert property (wr && addr == REG_ROLE |-> clr_seen)
        else $error("role written before alert clear");
    a_search_order: assert property (wr && addr == REG_CMD && wdata == CMD_SEARCH |-> role_seen)
        else $error("search issued before role write");
    c_role: cover property (wr && addr == REG_ROLE);
    c_search: cover property (wr && addr == REG_CMD && wdata == CMD_SEARCH);
    c_alert: cover property ($fell(alert_n));
endmodule : tcprc_properties

//--- dv/testbench.sv
// testbench: manager and controller joined on one link, plus a second
// controller whose link the bench drives directly. assumes 50 MHz sys_clk.
`timescale 1ns/1ps
module testbench;
    import tcprc_pkg::*;
    localparam logic [7:0] ROLES [5] = '{ROLE_SRC, ROLE_SRC_1A5, ROLE_SRC_3A, ROLE_SNK, ROLE_DRP};
    localparam tcprc_term_t TERMS [5] = '{TERM_PU_DEF, TERM_PU_1A5, TERM_PU_3A, TERM_PD, TERM_PD};
    localparam logic [7:0] CMDS [4] = '{CMD_SRC_DEF, CMD_SRC_HI, CMD_SRC_OFF, CMD_SINK};
    logic sys_clk;
    logic rst;
    logic start;
    logic [7:0] role_sel;
    logic ready;
    logic alert_seen;
    logic cc1_a;
    logic cc1_b;
    logic [7:0] vbus_b;
    tcprc_term_t cc1_term_a, cc2_term_a, cc1_term_b, cc2_term_b, prev;
    logic drain_a, drain_b, attached_a, attached_b;
    logic watch_a;
    logic att_alert;
    logic [7:0] d;
    int n_mismatch;
    int comparisons;
    tcprc_if bus_a ();
    tcprc_if bus_b ();
    tcprc_mgr i_tcprc_mgr (.sys_clk(sys_clk), .rst(rst), .bus(bus_a), .start(start),
        .role_sel(role_sel), .ready(ready), .alert_seen(alert_seen));
    tcprc_dev i_tcprc_dev (.sys_clk(sys_clk), .rst(rst), .bus(bus_a), .cc1_partner(cc1_a),
        .cc2_partner(1'b0), .vbus_level(8'h00), .cc1_term(cc1_term_a), .cc2_term(cc2_term_a),
        .drain_on(drain_a), .attached(attached_a));
    tcprc_dev i_tcprc_dev_b (.sys_clk(sys_clk), .rst(rst), .bus(bus_b), .cc1_partner(cc1_b),
        .cc2_partner(1'b0), .vbus_level(vbus_b), .cc1_term(cc1_term_b), .cc2_term(cc2_term_b),
        .drain_on(drain_b), .attached(attached_b));
    tcprc_properties i_tcprc_properties (.sys_clk(sys_clk), .rst(rst), .addr(bus_a.addr),
        .wdata(bus_a.wdata), .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata),
        .alert_n(bus_a.alert_n));
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    // alert line low at any point after the partner appears
    always @(posedge sys_clk) begin
        if (watch_a && bus_a.alert_n === 1'b0) att_alert <= 1'b1;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        bus_b.addr <= a;
        bus_b.wdata <= v;
        bus_b.wr <= 1'b1;
        @(posedge sys_clk);
        bus_b.wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        bus_b.addr <= a;
        bus_b.rd <= 1'b1;
        @(posedge sys_clk);
        bus_b.rd <= 1'b0;
        @(posedge sys_clk);
        v = bus_b.rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        check(v & m, e);
    endtask : rd_chk
    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    initial begin
        repeat (110000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        start = 1'b0;
        role_sel = 8'h00;
        cc1_a = 1'b0;
        cc1_b = 1'b0;
        vbus_b = 8'h5A;
        watch_a = 1'b0;
        att_alert = 1'b0;
        bus_b.addr = 8'h00;
        bus_b.wdata = 8'h00;
        bus_b.wr = 1'b0;
        bus_b.rd = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(REG_PWR_STATUS, 8'h40, 8'h40);
        rd_chk(REG_ALERT, 8'hFF, 8'h00);
        check({7'h00, bus_b.alert_n}, 8'h01);
        wr_reg(REG_PWR_CTRL, 8'h40);
        @(posedge sys_clk);
        start <= 1'b1;
        role_sel <= ROLE_SRC;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < 60000 && ready !== 1'b1; i++) @(posedge sys_clk);
        check({7'h00, ready}, 8'h01);
        check({7'h00, alert_seen}, 8'h01);
        // search write is taken after ready rises; terms follow a cycle later
        repeat (3) @(posedge sys_clk);
        check({5'h00, cc1_term_a}, {5'h00, TERM_PU_DEF});
        check({5'h00, cc2_term_a}, {5'h00, TERM_PU_DEF});
        cc1_a <= 1'b1;
        watch_a <= 1'b1;
        for (int i = 0; i < 2000 && attached_a !== 1'b1; i++) @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
        check({7'h00, attached_a}, 8'h01);
        check({7'h00, att_alert}, 8'h01);
        // second controller: bring-up by hand, then every role code
        rd_chk(REG_ALERT, 8'hFF, 8'h02);
        check({7'h00, bus_b.alert_n}, 8'h00);
        rd_chk(REG_PWR_STATUS, 8'h40, 8'h00);
        wr_reg(REG_ALERT, 8'h02);
        rd_chk(REG_ALERT, 8'hFF, 8'h00);
        check({7'h00, bus_b.alert_n}, 8'h01);
        wr_reg(REG_CC_GEN, 8'h03);
        rd_chk(REG_CC_GEN, 8'hFF, 8'h03);
        prev = TERM_OPEN;
        for (int k = 0; k < 5; k++) begin
            wr_reg(REG_ROLE, ROLES[k]);
            repeat (2) @(posedge sys_clk);
            check({5'h00, cc1_term_b}, {5'h00, prev});
            wr_reg(REG_CMD, CMD_SEARCH);
            repeat (2) @(posedge sys_clk);
            check({5'h00, cc1_term_b}, {5'h00, TERMS[k]});
            check({5'h00, cc2_term_b}, {5'h00, TERMS[k]});
            prev = TERMS[k];
        end
        for (int k = 0; k < 4; k++) begin
            wr_reg(REG_CMD, CMDS[k]);
            repeat (2) @(posedge sys_clk);
            check({5'h00, cc1_term_b}, {5'h00, TERM_PD});
            check({7'h00, drain_b}, 8'h00);
            rd_chk(REG_ALERT, 8'hFF, 8'h00);
        end
        wr_reg(8'h05, 8'hA5);
        rd_chk(8'h05, 8'hFF, 8'h00);
        wr_reg(REG_DRAIN_CTRL, 8'h01);
        rd_chk(REG_DRAIN_CTRL, 8'h01, 8'h01);
        wr_reg(REG_PWR_CTRL, 8'h44);
        repeat (10) @(posedge sys_clk);
        check({7'h00, drain_b}, 8'h00);
        wr_reg(REG_DRAIN_CTRL, 8'h00);
        wr_reg(REG_PWR_CTRL, 8'h40);
        wr_reg(REG_PWR_CTRL, 8'h44);
        for (int i = 0; i < 20 && drain_b !== 1'b1; i++) @(posedge sys_clk);
        check({7'h00, drain_b}, 8'h01);
        vbus_b <= 8'h30;
        d = 8'h00;
        for (int i = 0; i < MEAS_CYC / 3 + 100 && d !== 8'h30; i++) rd_reg(REG_VBUS_VOLT, d);
        check(d, 8'h30);
        // discharge ends at safe zero, then sink-side auto discharge
        wr_reg(REG_PWR_CTRL, 8'h00);
        vbus_b <= 8'h00;
        repeat (4) @(posedge sys_clk);
        check({7'h00, drain_b}, 8'h00);
        vbus_b <= 8'h5A;
        cc1_b <= 1'b1;
        wr_reg(REG_SNK_THR, 8'h40);
        wr_reg(REG_PWR_CTRL, 8'h10);
        rd_chk(REG_CC_STATUS, 8'h01, 8'h01);
        rd_chk(REG_ALERT, 8'h01, 8'h01);
        check({7'h00, drain_b}, 8'h00);
        vbus_b <= 8'h20;
        repeat (4) @(posedge sys_clk);
        check({7'h00, drain_b}, 8'h01);
        close_out();
    end
endmodule : testbench
